// file: rtl/rcs_defs.svh
`ifndef RCS_DEFS_SVH
`define RCS_DEFS_SVH

// register byte offsets
`define RCS_OFF_STATUS 12'h000
`define RCS_OFF_IRQ_STAT 12'h004
`define RCS_OFF_IRQ_MASK 12'h008

// flag bit positions
`define RCS_BIT_SUPPLY_POR 31
`define RCS_BIT_CORE_POR 30
`define RCS_BIT_CFG_ERR 27
`define RCS_BIT_CFG_FAIL 26
`define RCS_BIT_CFG_MISMATCH 9
`define RCS_BIT_PIN_RESET 7
`define RCS_BIT_SOFT_RESET 6
`define RCS_BIT_WATCHDOG 4
`define RCS_BIT_SLEEP 3
`define RCS_BIT_IDLE 2
`define RCS_BIT_BROWNOUT 1
`define RCS_BIT_POR 0

// implemented bits and reset values
`define RCS_IMPL_MASK 32'hCC0002DF
`define RCS_STATUS_RST 32'hC0000003
`define RCS_IRQ_STAT_RST 32'h00000000
`define RCS_IRQ_MASK_RST 32'h00000000

// axi answers
`define RCS_RESP_OKAY 2'h0
`define RCS_RESP_SLVERR 2'h2

// pin input synchroniser depth
`define RCS_SYNC_STAGES 3

`endif

// file: rtl/rcs_pkg.sv
package rcs_pkg;

  typedef struct packed {
    logic supply_por;
    logic core_por;
    logic cfg_err;
    logic cfg_fail;
    logic cfg_mismatch;
    logic pin_reset;
    logic soft_reset;
    logic watchdog;
    logic sleep;
    logic idle;
    logic wake;
    logic brownout;
    logic por;
  } rcs_events_t;

  typedef struct packed {
    logic [11:0] awaddr;
    logic awvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic wvalid;
    logic bready;
    logic [11:0] araddr;
    logic arvalid;
    logic rready;
  } rcs_axi_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic [1:0] bresp;
    logic bvalid;
    logic arready;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic rvalid;
  } rcs_axi_rsp_t;

endpackage

// file: rtl/rcs_pin_sync.sv
`timescale 1ns/1ps
`include "rcs_defs.svh"

module rcs_pin_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic sys_rst_in,
  // pin levels in, agreed pulses out
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] rise_out
);

  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] level;
    logic [WIDTH-1:0] rise;
  } rcs_sync_state_t;

  rcs_sync_state_t st_q;
  rcs_sync_state_t st_d;

  // stage two and three must agree before the level moves
  always_comb begin
    st_d = st_q;
    st_d.rise = '0;
    st_d.s1 = pin_in;
    st_d.s2 = st_q.s1;
    st_d.s3 = st_q.s2;
    for (int i = 0; i < WIDTH; i++) begin
      if (st_q.s2[i] == st_q.s3[i]) begin
        st_d.level[i] = st_q.s3[i];
        st_d.rise[i] = st_q.s3[i] & ~st_q.level[i];
      end
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign rise_out = st_q.rise;

endmodule

// file: rtl/rcs_reset_cause.sv
// Local design decisions: the address map and the AXI4-Lite register port.
`timescale 1ns/1ps
`include "rcs_defs.svh"

// Functional notes
// - supply power-on sets bit 31
// - core power-on sets bit 30
// - primary config read error sets bit 27
// - both config sets failing sets bit 26
// - config mismatch reset sets bit 9
// - master-clear pin reset sets bit 7
// - software reset sets bit 6
// - watchdog time-out sets bit 4
// - flags stay set until software clears
// - wake from sleep also sets bit 2
// - unimplemented bits read zero, ignore writes
module rcs_reset_cause (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic sys_rst_in,
  // cause events from on-chip logic, one-cycle pulses
  input wire logic supply_por_in,
  input wire logic core_por_in,
  input wire logic primary_cfg_read_error_in,
  input wire logic both_cfg_read_failure_in,
  input wire logic cfg_mismatch_in,
  input wire logic soft_reset_in,
  input wire logic watchdog_timeout_in,
  input wire logic sleep_in,
  input wire logic idle_in,
  input wire logic wake_in,
  input wire logic brownout_in,
  input wire logic por_in,
  // external pin
  input wire logic master_clear_pin_n_in,
  // axi4-lite slave
  input wire rcs_pkg::rcs_axi_req_t axi_req_in,
  output rcs_pkg::rcs_axi_rsp_t axi_rsp_out,
  // interrupt
  output logic irq_out
);

  typedef struct packed {
    logic [31:0] status;
    logic [31:0] irq_stat;
    logic [31:0] irq_mask;
    logic aw_held;
    logic [11:0] aw_addr;
    logic w_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic irq;
  } rcs_state_t;

  rcs_state_t st_q;
  rcs_state_t st_d;
  rcs_pkg::rcs_events_t ev;
  logic pin_rise;
  logic [31:0] set_vec;
  logic [31:0] wmask;
  logic [31:0] clr_status;
  logic [31:0] clr_irq;
  logic [31:0] wr_mask;
  logic wr_fire;
  logic rd_fire;
  logic [11:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic [11:0] rd_addr;

  // pin passes three flops, active low pin so invert
  rcs_pin_sync #(
    .WIDTH(1)
  ) u_pin_sync (
    .sys_clk_in(sys_clk_in),
    .sys_rst_in(sys_rst_in),
    .pin_in(~master_clear_pin_n_in),
    .rise_out(pin_rise)
  );

  // gather cause events
  always_comb begin
    ev = '0;
    ev.supply_por = supply_por_in;
    ev.core_por = core_por_in;
    ev.cfg_err = primary_cfg_read_error_in;
    ev.cfg_fail = both_cfg_read_failure_in;
    ev.cfg_mismatch = cfg_mismatch_in;
    ev.pin_reset = pin_rise;
    ev.soft_reset = soft_reset_in;
    ev.watchdog = watchdog_timeout_in;
    ev.sleep = sleep_in;
    ev.idle = idle_in;
    ev.wake = wake_in;
    ev.brownout = brownout_in;
    ev.por = por_in;
  end

  // set vector, one bit per cause, idle and wake share bit 2
  always_comb begin
    set_vec = '0;
    set_vec[`RCS_BIT_SUPPLY_POR] = ev.supply_por;
    set_vec[`RCS_BIT_CORE_POR] = ev.core_por;
    set_vec[`RCS_BIT_CFG_ERR] = ev.cfg_err;
    set_vec[`RCS_BIT_CFG_FAIL] = ev.cfg_fail;
    set_vec[`RCS_BIT_CFG_MISMATCH] = ev.cfg_mismatch;
    set_vec[`RCS_BIT_PIN_RESET] = ev.pin_reset;
    set_vec[`RCS_BIT_SOFT_RESET] = ev.soft_reset;
    set_vec[`RCS_BIT_WATCHDOG] = ev.watchdog;
    set_vec[`RCS_BIT_SLEEP] = ev.sleep;
    set_vec[`RCS_BIT_IDLE] = ev.idle | ev.wake;
    set_vec[`RCS_BIT_BROWNOUT] = ev.brownout;
    set_vec[`RCS_BIT_POR] = ev.por;
  end

  // write channel: address and data in either order
  always_comb begin
    wr_addr = st_q.aw_held ? st_q.aw_addr : axi_req_in.awaddr;
    wr_data = st_q.w_held ? st_q.w_data : axi_req_in.wdata;
    wr_strb = st_q.w_held ? st_q.w_strb : axi_req_in.wstrb;
    wr_fire = (st_q.aw_held | axi_req_in.awvalid) &
      (st_q.w_held | axi_req_in.wvalid) & ~st_q.bvalid;
    rd_addr = axi_req_in.araddr;
    rd_fire = axi_req_in.arvalid & ~st_q.rvalid;
  end

  // byte enables to bit mask
  always_comb begin
    for (int b = 0; b < 4; b++) begin
      wmask[b*8 +: 8] = {8{wr_strb[b]}};
    end
  end

  // software write-zero clears status, write-one clears irq
  always_comb begin
    clr_status = '0;
    clr_irq = '0;
    wr_mask = '0;
    if (wr_fire) begin
      if (wr_addr == `RCS_OFF_STATUS) begin
        clr_status = wmask & ~wr_data & `RCS_IMPL_MASK;
      end
      if (wr_addr == `RCS_OFF_IRQ_STAT) begin
        clr_irq = wmask & wr_data & `RCS_IMPL_MASK;
      end
      if (wr_addr == `RCS_OFF_IRQ_MASK) begin
        wr_mask = wmask;
      end
    end
  end

  always_comb begin
    st_d = st_q;
    // flags: clear first, set wins, others untouched
    st_d.status = ((st_q.status & ~clr_status) | set_vec) &
      `RCS_IMPL_MASK;
    st_d.irq_stat = ((st_q.irq_stat & ~clr_irq) | set_vec) &
      `RCS_IMPL_MASK;
    st_d.irq_mask = ((st_q.irq_mask & ~wr_mask) |
      (wr_data & wr_mask)) & `RCS_IMPL_MASK;
    st_d.irq = |(st_d.irq_stat & st_d.irq_mask);
    // write address and data capture
    if (axi_req_in.awvalid & ~st_q.aw_held & ~st_q.bvalid &
      ~wr_fire) begin
      st_d.aw_held = 1'b1;
      st_d.aw_addr = axi_req_in.awaddr;
    end
    if (axi_req_in.wvalid & ~st_q.w_held & ~st_q.bvalid &
      ~wr_fire) begin
      st_d.w_held = 1'b1;
      st_d.w_data = axi_req_in.wdata;
      st_d.w_strb = axi_req_in.wstrb;
    end
    if (wr_fire) begin
      st_d.aw_held = 1'b0;
      st_d.w_held = 1'b0;
      st_d.bvalid = 1'b1;
      case (wr_addr)
        `RCS_OFF_STATUS, `RCS_OFF_IRQ_STAT, `RCS_OFF_IRQ_MASK:
          st_d.bresp = `RCS_RESP_OKAY;
        default:
          st_d.bresp = `RCS_RESP_SLVERR;
      endcase
    end else if (st_q.bvalid & axi_req_in.bready) begin
      st_d.bvalid = 1'b0;
    end
    // read channel
    if (rd_fire) begin
      st_d.rvalid = 1'b1;
      st_d.rresp = `RCS_RESP_OKAY;
      case (rd_addr)
        `RCS_OFF_STATUS:
          st_d.rdata = st_q.status & `RCS_IMPL_MASK;
        `RCS_OFF_IRQ_STAT:
          st_d.rdata = st_q.irq_stat;
        `RCS_OFF_IRQ_MASK:
          st_d.rdata = st_q.irq_mask;
        default: begin
          st_d.rdata = 32'h00000000;
          st_d.rresp = `RCS_RESP_SLVERR;
        end
      endcase
    end else if (st_q.rvalid & axi_req_in.rready) begin
      st_d.rvalid = 1'b0;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      st_q <= '0;
      st_q.status <= `RCS_STATUS_RST;
      st_q.irq_stat <= `RCS_IRQ_STAT_RST;
      st_q.irq_mask <= `RCS_IRQ_MASK_RST;
    end else begin
      st_q <= st_d;
    end
  end

  // bus answers
  always_comb begin
    axi_rsp_out.awready = ~st_q.aw_held & ~st_q.bvalid;
    axi_rsp_out.wready = ~st_q.w_held & ~st_q.bvalid;
    axi_rsp_out.bvalid = st_q.bvalid;
    axi_rsp_out.bresp = st_q.bresp;
    axi_rsp_out.arready = ~st_q.rvalid;
    axi_rsp_out.rvalid = st_q.rvalid;
    axi_rsp_out.rdata = st_q.rdata;
    axi_rsp_out.rresp = st_q.rresp;
  end

  assign irq_out = st_q.irq;

endmodule

// file: verif/rcs_reset_cause_assertions.sv
`timescale 1ns/1ps
`include "rcs_defs.svh"
module rcs_reset_cause_assertions (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic sys_rst_in,
  // cause events
  input wire logic supply_por_in,
  input wire logic core_por_in,
  input wire logic primary_cfg_read_error_in,
  input wire logic both_cfg_read_failure_in,
  input wire logic cfg_mismatch_in,
  input wire logic soft_reset_in,
  input wire logic watchdog_timeout_in,
  input wire logic wake_in,
  // register bus
  input wire rcs_pkg::rcs_axi_req_t axi_req_in,
  input wire rcs_pkg::rcs_axi_rsp_t axi_rsp_out
);
  logic [7:0] ev, pend_q, rp_q;
  logic rs_q, wr_hs, ar_hs;
  assign ev = {supply_por_in, core_por_in, primary_cfg_read_error_in,
    both_cfg_read_failure_in, cfg_mismatch_in, soft_reset_in,
    watchdog_timeout_in, wake_in};
  assign ar_hs = axi_req_in.arvalid && axi_rsp_out.arready;
  assign wr_hs = (axi_req_in.awvalid && axi_rsp_out.awready) ||
    (axi_req_in.wvalid && axi_rsp_out.wready);
  // events since the last write, copied at each read
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      pend_q <= 8'h00;
      rp_q <= 8'h00;
      rs_q <= 1'b0;
    end else begin
      pend_q <= ev | (wr_hs ? 8'h00 : pend_q);
      if (ar_hs) begin
        rp_q <= pend_q;
        rs_q <= axi_req_in.araddr == `RCS_OFF_STATUS;
      end
    end
  end
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (sys_rst_in);
  sequence s_stat_rd;
    axi_rsp_out.rvalid && rs_q;
  endsequence
  property p_flag(k, b);
    s_stat_rd ##0 rp_q[k] |-> axi_rsp_out.rdata[b];
  endproperty
  chk_supply_flag: assert property (p_flag(7, 31))
    else $error("supply flag lost");
  chk_core_flag: assert property (p_flag(6, 30))
    else $error("core flag lost");
  chk_cfg_err: assert property (p_flag(5, 27))
    else $error("config error flag lost");
  chk_cfg_fail: assert property (p_flag(4, 26))
    else $error("config failure flag lost");
  chk_mismatch_flag: assert property (p_flag(3, 9))
    else $error("mismatch flag lost");
  chk_soft_flag: assert property (p_flag(2, 6))
    else $error("soft reset flag lost");
  chk_watchdog_flag: assert property (p_flag(1, 4))
    else $error("watchdog flag lost");
  chk_wake_idle: assert property (p_flag(0, 2))
    else $error("wake did not set idle");
  chk_unimpl_zero: assert property (
    s_stat_rd |-> (axi_rsp_out.rdata & ~`RCS_IMPL_MASK) == 32'h00000000)
    else $error("unimplemented bit set");
endmodule
bind rcs_reset_cause rcs_reset_cause_assertions u_rcs_reset_cause_assertions (
  .sys_clk_in, .sys_rst_in, .supply_por_in, .core_por_in,
  .primary_cfg_read_error_in, .both_cfg_read_failure_in, .cfg_mismatch_in,
  .soft_reset_in, .watchdog_timeout_in, .wake_in, .axi_req_in, .axi_rsp_out);

// file: verif/rcs_reset_cause_tb.sv
`timescale 1ns/1ps
module rcs_reset_cause_tb;
  logic clk, rst, pin_n, irq;
  logic [11:0] ev;
  logic [31:0] e;
  rcs_pkg::rcs_axi_req_t rq;
  rcs_pkg::rcs_axi_rsp_t rs;
  int failures, n_checks, i;
  int bt [12] = '{0, 1, 2, 2, 3, 4, 6, 9, 26, 27, 30, 31};
  rcs_reset_cause u_rcs_reset_cause (
    .sys_clk_in(clk), .sys_rst_in(rst),
    .supply_por_in(ev[11]), .core_por_in(ev[10]),
    .primary_cfg_read_error_in(ev[9]), .both_cfg_read_failure_in(ev[8]),
    .cfg_mismatch_in(ev[7]), .soft_reset_in(ev[6]),
    .watchdog_timeout_in(ev[5]), .sleep_in(ev[4]), .idle_in(ev[3]),
    .wake_in(ev[2]), .brownout_in(ev[1]), .por_in(ev[0]),
    .master_clear_pin_n_in(pin_n), .axi_req_in(rq), .axi_rsp_out(rs),
    .irq_out(irq));
  always #2 clk = ~clk;
  task summarize;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] x);
    n_checks++;
    if (g !== x) begin
      failures++;
      $display("ERROR %0t got %h exp %h", $time, g, x);
    end
  endtask
  task hang;
    failures++;
    $display("ERROR %0t bus timeout", $time);
    summarize;
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
    input logic [1:0] xr);
    int n;
    @(posedge clk);
    rq.awaddr <= a;
    rq.wdata <= d;
    rq.wstrb <= s;
    rq.awvalid <= 1'b1;
    rq.wvalid <= 1'b1;
    rq.bready <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge clk);
      if (rs.awready) rq.awvalid <= 1'b0;
      if (rs.wready) rq.wvalid <= 1'b0;
      if (rs.bvalid) break;
    end
    rq.bready <= 1'b0;
    if (n == 40) hang;
    chk({30'h0, rs.bresp}, {30'h0, xr});
  endtask
  task rdc(input logic [11:0] a, input logic [31:0] x,
    input logic [1:0] xr);
    int n;
    @(posedge clk);
    rq.araddr <= a;
    rq.arvalid <= 1'b1;
    rq.rready <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge clk);
      if (rs.arready) rq.arvalid <= 1'b0;
      if (rs.rvalid) break;
    end
    rq.rready <= 1'b0;
    if (n == 40) hang;
    chk(rs.rdata, x);
    chk({30'h0, rs.rresp}, {30'h0, xr});
  endtask
  task pulse(input int k);
    @(posedge clk);
    ev[k] <= 1'b1;
    @(posedge clk);
    ev[k] <= 1'b0;
  endtask
  initial begin
    clk = 1'b0;
    rst = 1'b1;
    ev = 12'h000;
    pin_n = 1'b1;
    rq = '0;
    failures = 0;
    n_checks = 0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    rdc(12'h000, 32'hC0000003, 2'h0);
    wr(12'h000, 32'hFFFFFFFF, 4'hF, 2'h0);
    rdc(12'h000, 32'hC0000003, 2'h0);
    wr(12'h000, 32'h00000000, 4'hF, 2'h0);
    rdc(12'h000, 32'h00000000, 2'h0);
    $display("test reset and clear done");
    e = 32'h00000000;
    for (i = 0; i < 12; i++) begin
      pulse(i);
      e[bt[i]] = 1'b1;
      rdc(12'h000, e, 2'h0);
    end
    pin_n <= 1'b0;
    repeat (10) @(posedge clk);
    pin_n <= 1'b1;
    e[7] = 1'b1;
    rdc(12'h000, e, 2'h0);
    e[31] = 1'b0;
    wr(12'h000, e, 4'hF, 2'h0);
    rdc(12'h000, e, 2'h0);
    $display("test cause flags done");
    wr(12'h004, 32'hFFFFFFFF, 4'hF, 2'h0);
    wr(12'h008, 32'h80000000, 4'hF, 2'h0);
    pulse(11);
    rdc(12'h004, 32'h80000000, 2'h0);
    chk({31'h0, irq}, 32'h00000001);
    wr(12'h004, 32'h80000000, 4'hF, 2'h0);
    pulse(10);
    rdc(12'h004, 32'h40000000, 2'h0);
    chk({31'h0, irq}, 32'h00000000);
    wr(12'h008, 32'hFFFFFFFF, 4'h1, 2'h0);
    rdc(12'h008, 32'h800000DF, 2'h0);
    chk({31'h0, irq}, 32'h00000000);
    e[31] = 1'b1;
    wr(12'h010, 32'h00000000, 4'hF, 2'h2);
    rdc(12'h000, e, 2'h0);
    rdc(12'h010, 32'h00000000, 2'h2);
    $display("test interrupt and unmapped done");
    summarize;
  end
endmodule
